// ### rtcia_cfg.svh
// Functional notes
// - timer enabled: countdown end sets timer flag
// - timer flag holds until software writes zero
// - timer disabled: no flag, no interrupt
// - zero write to timer flag drops output
// - bits 7..5 of enable, flags read zero
// - alarm field msb enables its comparison
// - enabled fields compared against current time
// - alarm enabled: first full match sets flag
// - alarm flag holds until zero write
// - only a new match sets alarm again
// - alarm disabled: no flag, no interrupt
// - interrupt pin active low, open drain
// - output reflects enabled flag bits 0..4 at 02h
// - low volt one: clear flag and status
// - low volt two: clear flag and status
// - reset interrupt: clear flag and status
// - self recovery reset sets reset flag
// - countdown end means counter reached zero
`ifndef RTCIA_CFG_SVH
`define RTCIA_CFG_SVH
`define RTCIA_ADDR_IRQ_EN   8'h01
`define RTCIA_ADDR_IRQ_FLAG 8'h02
`define RTCIA_ADDR_STATUS   8'h03
`define RTCIA_BIT_ALARM     0
`define RTCIA_BIT_TIMER     1
`define RTCIA_BIT_VLOW1     2
`define RTCIA_BIT_VLOW2     3
`define RTCIA_BIT_RESET     4
`define RTCIA_NUM_SRC       5
`define RTCIA_NUM_FIELDS    7
`define RTCIA_FIELD_EN_BIT  7
`define RTCIA_IRQ_EN_RST    5'h00
`define RTCIA_IRQ_FLAG_RST  5'h00
`define RTCIA_STATUS_RST    3'h0
`endif

// ### rtcia_pkg.sv
package rtcia_pkg;
  typedef struct packed {
    logic [4:0] irq_en;
    logic [4:0] irq_flag;
    logic [2:0] status;
    logic       match_prev;
    logic       vlow1_prev;
    logic       vlow2_prev;
    logic [7:0] rdata;
  } rtcia_state_t;
  typedef struct packed {
    logic match;
  } rtcia_cmp_state_t;
endpackage

// ### rtcia_cmp_if.sv
`timescale 1ns/10ps
interface rtcia_cmp_if;
  logic [7:0] alarm_field;
  logic [7:0] time_field;
  logic       field_enabled;
  logic       match;
  modport cmp (input alarm_field, input time_field, output field_enabled, output match);
  modport ctl (output alarm_field, output time_field, input field_enabled, input match);
endinterface

// ### rtcia_field_cmp.sv
`timescale 1ns/10ps
`include "rtcia_cfg.svh"
module rtcia_field_cmp (
  // clock and reset
  input wire logic   sys_clk,
  input wire logic   srst,
  // field pair
  rtcia_cmp_if.cmp   cmp_if
);
  rtcia_pkg::rtcia_cmp_state_t st_q;
  rtcia_pkg::rtcia_cmp_state_t st_d;

  assign cmp_if.field_enabled = cmp_if.alarm_field[`RTCIA_FIELD_EN_BIT];
  assign cmp_if.match         = st_q.match;

  always_comb begin
    st_d = st_q;
    // a disabled field does not block the wired-and of the others
    if (cmp_if.alarm_field[`RTCIA_FIELD_EN_BIT]) begin
      st_d.match = (cmp_if.alarm_field[6:0] == cmp_if.time_field[6:0]);
    end else begin
      st_d.match = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule

// ### rtcia_top.sv
`timescale 1ns/10ps
`include "rtcia_cfg.svh"
module rtcia_top (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  srst,
  // register port
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  // event sources
  input  wire logic                  countdown_zero,
  input  wire logic                  low_volt_one_det,
  input  wire logic                  low_volt_two_det,
  input  wire logic                  self_recovery_rst,
  // alarm and watch fields
  input  wire logic [6:0][7:0]       alarm_regs,
  input  wire logic [6:0][7:0]       time_regs,
  // interrupt pin
  output logic                       irq_n_out,
  output logic                       irq_n_oe
);
  rtcia_pkg::rtcia_state_t st_q;
  rtcia_pkg::rtcia_state_t st_d;

  logic [`RTCIA_NUM_FIELDS-1:0] field_match;
  logic [`RTCIA_NUM_FIELDS-1:0] field_en;
  logic                         alarm_match;
  logic                         alarm_event;
  logic                         vlow1_event;
  logic                         vlow2_event;
  logic [4:0]                   src_event;
  logic                         wr_en;
  logic                         wr_flag;
  logic                         wr_status;
  logic [4:0]                   flag_clr;
  logic [2:0]                   status_clr;
  logic [2:0]                   status_set;
  logic [2:0]                   status_hold;
  logic [4:0]                   flag_set;

  genvar gi;
  generate
    for (gi = 0; gi < `RTCIA_NUM_FIELDS; gi++) begin : g_field
      rtcia_cmp_if cmp_bus ();
      assign cmp_bus.alarm_field = alarm_regs[gi];
      assign cmp_bus.time_field  = time_regs[gi];
      assign field_match[gi]     = cmp_bus.match;
      assign field_en[gi]        = cmp_bus.field_enabled;
      rtcia_field_cmp u_cmp (
        .sys_clk (sys_clk),
        .srst    (srst),
        .cmp_if  (cmp_bus.cmp)
      );
    end
  endgenerate

  // with no field enabled the alarm can never fire
  assign alarm_match = (&field_match) & (|field_en);
  // edge only: a match that persists after a clear cannot re-fire
  assign alarm_event = alarm_match & ~st_q.match_prev;
  assign vlow1_event = low_volt_one_det & ~st_q.vlow1_prev;
  assign vlow2_event = low_volt_two_det & ~st_q.vlow2_prev;

  always_comb begin
    src_event                     = '0;
    src_event[`RTCIA_BIT_ALARM]   = alarm_event;
    src_event[`RTCIA_BIT_TIMER]   = countdown_zero;
    src_event[`RTCIA_BIT_VLOW1]   = vlow1_event;
    src_event[`RTCIA_BIT_VLOW2]   = vlow2_event;
    src_event[`RTCIA_BIT_RESET]   = self_recovery_rst;
  end

  // a recovery is recorded even while its interrupt is masked, so software can still see it
  always_comb begin
    flag_set                   = src_event & st_q.irq_en;
    flag_set[`RTCIA_BIT_RESET] = self_recovery_rst;
  end

  assign wr_en     = reg_wr & (reg_addr == `RTCIA_ADDR_IRQ_EN);
  assign wr_flag   = reg_wr & (reg_addr == `RTCIA_ADDR_IRQ_FLAG);
  assign wr_status = reg_wr & (reg_addr == `RTCIA_ADDR_STATUS);
  // zero clears, one keeps
  assign flag_clr   = wr_flag ? ~reg_wdata[4:0] : 5'h00;
  assign status_clr = wr_status ? ~reg_wdata[4:2] : 3'h0;
  assign status_set = {self_recovery_rst, vlow2_event, vlow1_event};
  assign status_hold = st_q.status | status_set;

  always_comb begin
    st_d            = st_q;
    st_d.match_prev = alarm_match;
    st_d.vlow1_prev = low_volt_one_det;
    st_d.vlow2_prev = low_volt_two_det;
    if (wr_en) begin
      st_d.irq_en = reg_wdata[4:0];
    end
    // status bits: set wins over a clear in the same cycle
    st_d.status = (st_q.status & ~status_clr) | status_set;
    // flags set only while enabled, the reset flag always; set wins over clear
    st_d.irq_flag = (st_q.irq_flag & ~flag_clr) | flag_set;
    // a low-voltage or reset flag cannot be released while its status bit stays set
    if (st_q.irq_flag[`RTCIA_BIT_VLOW1] & status_hold[0]) begin
      st_d.irq_flag[`RTCIA_BIT_VLOW1] = 1'b1;
    end
    if (st_q.irq_flag[`RTCIA_BIT_VLOW2] & status_hold[1]) begin
      st_d.irq_flag[`RTCIA_BIT_VLOW2] = 1'b1;
    end
    if (st_q.irq_flag[`RTCIA_BIT_RESET] & status_hold[2]) begin
      st_d.irq_flag[`RTCIA_BIT_RESET] = 1'b1;
    end
    if (reg_rd) begin
      case (reg_addr)
        `RTCIA_ADDR_IRQ_EN: begin
          st_d.rdata = {3'h0, st_q.irq_en};
        end
        `RTCIA_ADDR_IRQ_FLAG: begin
          st_d.rdata = {3'h0, st_q.irq_flag};
        end
        `RTCIA_ADDR_STATUS: begin
          st_d.rdata = {3'h0, st_q.status, 2'h0};
        end
        default: begin
          st_d.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q            <= '0;
      st_q.irq_en     <= `RTCIA_IRQ_EN_RST;
      st_q.irq_flag   <= `RTCIA_IRQ_FLAG_RST;
      st_q.status     <= `RTCIA_STATUS_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;
  // pin is only ever pulled low; the pull-up makes the high level
  assign irq_n_out = 1'b0;
  // combinational from the flag flops, so a zero write releases the pin at once
  assign irq_n_oe  = |(st_q.irq_en & st_q.irq_flag);

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  property p_timer_set;
    countdown_zero && st_q.irq_en[`RTCIA_BIT_TIMER] |=> st_q.irq_flag[`RTCIA_BIT_TIMER] ##0 irq_n_oe;
  endproperty
  a_timer_set: assert property (p_timer_set) else $error("timer flag not set");

  property p_timer_hold;
    st_q.irq_flag[`RTCIA_BIT_TIMER] && !(wr_flag && !reg_wdata[`RTCIA_BIT_TIMER])
      |=> st_q.irq_flag[`RTCIA_BIT_TIMER];
  endproperty
  a_timer_hold: assert property (p_timer_hold) else $error("timer flag lost");

  property p_timer_off;
    !st_q.irq_en[`RTCIA_BIT_TIMER] && !st_q.irq_flag[`RTCIA_BIT_TIMER]
      |=> !st_q.irq_flag[`RTCIA_BIT_TIMER];
  endproperty
  a_timer_off: assert property (p_timer_off) else $error("timer flag set while disabled");

  property p_timer_clear;
    wr_flag && !reg_wdata[`RTCIA_BIT_TIMER] && flag_set == 5'h00
      && (st_q.irq_en & st_q.irq_flag) == 5'h02
      |=> !irq_n_oe;
  endproperty
  a_timer_clear: assert property (p_timer_clear) else $error("pin not released");

  property p_read_upper;
    reg_rd && (reg_addr == `RTCIA_ADDR_IRQ_EN || reg_addr == `RTCIA_ADDR_IRQ_FLAG)
      |=> reg_rdata[7:5] == 3'h0 && reg_rdata[4:0] == $past(reg_addr[1] ? st_q.irq_flag : st_q.irq_en);
  endproperty
  a_read_upper: assert property (p_read_upper) else $error("bad read data");

  property p_alarm_set;
    alarm_event && st_q.irq_en[`RTCIA_BIT_ALARM] |=> st_q.irq_flag[`RTCIA_BIT_ALARM];
  endproperty
  a_alarm_set: assert property (p_alarm_set) else $error("alarm flag not set");

  property p_alarm_once;
    alarm_match && st_q.match_prev && !st_q.irq_flag[`RTCIA_BIT_ALARM]
      |=> !st_q.irq_flag[`RTCIA_BIT_ALARM];
  endproperty
  a_alarm_once: assert property (p_alarm_once) else $error("alarm refired on held match");

  property p_alarm_off;
    !st_q.irq_en[`RTCIA_BIT_ALARM] && !st_q.irq_flag[`RTCIA_BIT_ALARM]
      |=> !st_q.irq_flag[`RTCIA_BIT_ALARM];
  endproperty
  a_alarm_off: assert property (p_alarm_off) else $error("alarm flag set while disabled");

  property p_no_high;
    irq_n_out == 1'b0;
  endproperty
  a_no_high: assert property (p_no_high) else $error("pin driven high");

  property p_vlow1_hold;
    st_q.irq_flag[`RTCIA_BIT_VLOW1] && st_q.status[0] && !wr_status
      |=> st_q.irq_flag[`RTCIA_BIT_VLOW1];
  endproperty
  a_vlow1_hold: assert property (p_vlow1_hold) else $error("vlow1 flag released early");

  property p_srec_flag;
    self_recovery_rst |=> st_q.irq_flag[`RTCIA_BIT_RESET] && st_q.status[2];
  endproperty
  a_srec_flag: assert property (p_srec_flag) else $error("reset status not set");

  property p_write_one;
    wr_flag && reg_wdata[4:0] == 5'h1f
      |=> st_q.irq_flag == ($past(st_q.irq_flag) | $past(flag_set));
  endproperty
  a_write_one: assert property (p_write_one) else $error("write of one changed flag");

  property p_timer_zero;
    wr_flag && !reg_wdata[`RTCIA_BIT_TIMER] && !countdown_zero
      |=> !st_q.irq_flag[`RTCIA_BIT_TIMER];
  endproperty
  a_timer_zero: assert property (p_timer_zero) else $error("timer flag not cleared");

  property p_timer_only;
    !countdown_zero && !st_q.irq_flag[`RTCIA_BIT_TIMER]
      |=> !st_q.irq_flag[`RTCIA_BIT_TIMER];
  endproperty
  a_timer_only: assert property (p_timer_only) else $error("timer flag without zero");

  property p_alarm_hold;
    st_q.irq_flag[`RTCIA_BIT_ALARM] && !(wr_flag && !reg_wdata[`RTCIA_BIT_ALARM])
      |=> st_q.irq_flag[`RTCIA_BIT_ALARM];
  endproperty
  a_alarm_hold: assert property (p_alarm_hold) else $error("alarm flag lost");

  property p_alarm_zero;
    wr_flag && !reg_wdata[`RTCIA_BIT_ALARM] && !alarm_event
      |=> !st_q.irq_flag[`RTCIA_BIT_ALARM];
  endproperty
  a_alarm_zero: assert property (p_alarm_zero) else $error("alarm flag not cleared");

  property p_alarm_clear;
    wr_flag && !reg_wdata[`RTCIA_BIT_ALARM] && flag_set == 5'h00
      && (st_q.irq_en & st_q.irq_flag) == 5'h01 |=> !irq_n_oe;
  endproperty
  a_alarm_clear: assert property (p_alarm_clear) else $error("pin held after alarm clear");

  property p_alarm_only;
    !alarm_event && !st_q.irq_flag[`RTCIA_BIT_ALARM]
      |=> !st_q.irq_flag[`RTCIA_BIT_ALARM];
  endproperty
  a_alarm_only: assert property (p_alarm_only) else $error("alarm flag without new match");

  property p_vlow1_set;
    vlow1_event && st_q.irq_en[`RTCIA_BIT_VLOW1]
      |=> st_q.irq_flag[`RTCIA_BIT_VLOW1] && st_q.status[0];
  endproperty
  a_vlow1_set: assert property (p_vlow1_set) else $error("vlow1 flag not set");

  property p_vlow1_gate;
    !vlow1_event && !st_q.irq_flag[`RTCIA_BIT_VLOW1]
      |=> !st_q.irq_flag[`RTCIA_BIT_VLOW1];
  endproperty
  a_vlow1_gate: assert property (p_vlow1_gate) else $error("vlow1 flag without event");

  property p_status_clear;
    wr_status && !reg_wdata[`RTCIA_BIT_VLOW1] && !vlow1_event
      |=> !st_q.status[0];
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("vlow1 status kept");

  property p_vlow2_set;
    vlow2_event && st_q.irq_en[`RTCIA_BIT_VLOW2]
      |=> st_q.irq_flag[`RTCIA_BIT_VLOW2] && st_q.status[1];
  endproperty
  a_vlow2_set: assert property (p_vlow2_set) else $error("vlow2 flag not set");

  property p_vlow2_hold;
    st_q.irq_flag[`RTCIA_BIT_VLOW2] && st_q.status[1] && !wr_status
      |=> st_q.irq_flag[`RTCIA_BIT_VLOW2];
  endproperty
  a_vlow2_hold: assert property (p_vlow2_hold) else $error("vlow2 flag released early");

  property p_reset_hold;
    st_q.irq_flag[`RTCIA_BIT_RESET] && st_q.status[2] && !wr_status
      |=> st_q.irq_flag[`RTCIA_BIT_RESET];
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset flag released early");

  property p_pin_low;
    (st_q.irq_en & st_q.irq_flag) != 5'h00
      |-> irq_n_oe;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin not pulled low");

  property p_pin_release;
    (st_q.irq_en & st_q.irq_flag) == 5'h00
      |-> !irq_n_oe;
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("pin pulled without flag");

  c_timer_irq: cover property (countdown_zero && st_q.irq_en[`RTCIA_BIT_TIMER] ##1 irq_n_oe);
  c_alarm_irq: cover property (alarm_event && st_q.irq_en[`RTCIA_BIT_ALARM] ##1 irq_n_oe);
  c_release:   cover property (irq_n_oe ##1 wr_flag ##1 !irq_n_oe);
  c_vlow_irq:  cover property (vlow1_event && st_q.irq_en[`RTCIA_BIT_VLOW1] ##1 irq_n_oe);
  c_reset_irq: cover property (self_recovery_rst && st_q.irq_en[`RTCIA_BIT_RESET] ##1 irq_n_oe);
endmodule

// ### rtcia_host.sv
`timescale 1ns/10ps
module rtcia_host (
  // clock
  input  wire logic       sys_clk,
  // register port
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  // interrupt pin
  input  wire logic       irq_n_out,
  input  wire logic       irq_n_oe,
  output logic            irq_pin
);
  // board pull-up: a released pin reads high
  assign irq_pin = irq_n_oe ? irq_n_out : 1'b1;
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    // stale data must not look like a valid write
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule

// ### rtcia_top_tb.sv
`timescale 1ns/10ps
module rtcia_top_tb;
  logic             sys_clk = 1'b0;
  logic             srst = 1'b1;
  logic [7:0]       reg_addr, reg_wdata, reg_rdata, v, d;
  logic             reg_wr, reg_rd, irq_n_out, irq_n_oe, irq_pin;
  logic             countdown_zero, low_volt_one_det, low_volt_two_det, self_recovery_rst;
  logic [6:0][7:0]  alarm_regs, time_regs;
  int               n_fail, samples_checked, men, mflg, mst;
  always #12.5 sys_clk = ~sys_clk;
  rtcia_top dut_u (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .countdown_zero(countdown_zero), .low_volt_one_det(low_volt_one_det),
    .low_volt_two_det(low_volt_two_det), .self_recovery_rst(self_recovery_rst),
    .alarm_regs(alarm_regs), .time_regs(time_regs), .irq_n_out(irq_n_out),
    .irq_n_oe(irq_n_oe));
  rtcia_host host_u (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_n_out(irq_n_out),
    .irq_n_oe(irq_n_oe), .irq_pin(irq_pin));
  task automatic final_report();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic pin_chk();
    chk("irq_pin", {7'h00, ((mflg & men) == 0)}, {7'h00, irq_pin});
  endtask
  task automatic cmp_all();
    host_u.rd(8'h01, d);
    chk("irq_enable", men[7:0], d);
    host_u.rd(8'h02, d);
    chk("irq_flag", mflg[7:0], d);
    host_u.rd(8'h03, d);
    chk("status", mst[7:0], d);
    pin_chk();
  endtask
  task automatic wrm(input logic [7:0] a, input logic [7:0] w);
    host_u.wr(a, w);
    if (a == 8'h01) men = w & 8'h1f;
    if (a == 8'h03) mst = mst & w & 8'h1c;
    // a low-volt or reset flag stays while its status bit is still set
    if (a == 8'h02) for (int i = 0; i < 5; i++)
      if (!w[i] && !(i > 1 && mst[i])) mflg[i] = 0;
    #1;
    pin_chk();
  endtask
  task automatic ev(input int i);
    @(posedge sys_clk);
    case (i)
      0: time_regs[0] <= v + 8'h01;
      1: countdown_zero <= 1'b1;
      2: low_volt_one_det <= 1'b1;
      3: low_volt_two_det <= 1'b1;
      default: self_recovery_rst <= 1'b1;
    endcase
    @(posedge sys_clk);
    {countdown_zero, low_volt_one_det, low_volt_two_det, self_recovery_rst} <= 4'h0;
    time_regs[0] <= v;
    repeat (4) @(posedge sys_clk);
    // a recovery reset is flagged even while its interrupt is masked
    if (men[i] || i == 4) mflg[i] = 1;
    if (i > 1) mst[i] = 1;
  endtask
  initial begin
    n_fail = 0;
    samples_checked = 0;
    {men, mflg, mst} = '0;
    {countdown_zero, low_volt_one_det, low_volt_two_det, self_recovery_rst} = 4'h0;
    void'($urandom(92));
    v = 8'($urandom % 96);
    // disabled fields get random values that must not affect matching
    for (int f = 0; f < 7; f++) begin
      alarm_regs[f] = 8'($urandom) & 8'h7f;
      time_regs[f] = 8'($urandom);
    end
    alarm_regs[0] = 8'h80 | v;
    time_regs[0] = v + 8'h01;
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    cmp_all();
    host_u.rd(8'h05, d);
    chk("unmapped", 8'h00, d);
    wrm(8'h01, 8'hff);
    cmp_all();
    for (int p = 0; p < 2; p++) begin
      wrm(8'h01, p ? 8'hff : 8'he0);
      for (int i = 0; i < 5; i++) begin
        ev(i);
        cmp_all();
        wrm(8'h02, 8'hff);
        cmp_all();
        if (i > 1) begin
          wrm(8'h02, 8'h00);
          cmp_all();
          wrm(8'h03, 8'h00);
        end
        wrm(8'h02, 8'h00);
        repeat (4) @(posedge sys_clk);
        cmp_all();
      end
    end
    final_report();
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    final_report();
  end
endmodule
